// ==== dmc_pkg.sv ====
// Shared constants for the sixteen-channel DAC mode control block
package dmc_pkg;

  // Serial command word layout
  localparam int WORD_BITS   = 18;
  localparam int MODE_HI     = 17;
  localparam int MODE_LO     = 16;
  localparam int CHAN_HI     = 15;
  localparam int CHAN_LO     = 12;
  localparam int CODE_HI     = 11;
  localparam int STEP_HI     = 6;
  localparam int CODE_BITS   = 12;
  localparam int LEVEL_BITS  = 14;
  localparam int CHANNELS    = 16;
  localparam logic [4:0] LAST_BIT = 5'h11;
  localparam logic [4:0] FULL_CNT = 5'h12;

  // Mode field encodings
  localparam logic [1:0] MODE_LOAD = 2'h0;
  localparam logic [1:0] MODE_INC  = 2'h1;
  localparam logic [1:0] MODE_DEC  = 2'h2;
  localparam logic [1:0] MODE_NOP  = 2'h3;

  // Code after power-on or reset pin
  localparam logic [11:0] CODE_RESET = 12'h800;
  localparam logic [13:0] LEVEL_MAX  = 14'h3FFF;

  // Timing: pclk period and busy durations
  localparam int PCLK_PS      = 5000;
  localparam int LOAD_TIME_NS = 25;
  localparam int LOAD_TIME_US = 25;
  localparam int STEP_TIME_US = 1;
  localparam int LOAD_CYC = (LOAD_TIME_US * 1000000 + PCLK_PS - 1) / PCLK_PS;
  localparam int STEP_CYC = (STEP_TIME_US * 1000000) / PCLK_PS;
  localparam int SAR_CYC  = 16;

  // APB register byte offsets
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_IRQ_ST  = 12'h008;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_EN  = 12'h010;
  localparam logic [11:0] ADDR_CH_BASE = 12'h040;
  localparam logic [11:0] ADDR_CH_END  = 12'h07C;

  // Control register fields and reset
  localparam int CTRL_LINK_EN = 0;
  localparam logic [0:0] CTRL_RESET = 1'h1;

  // Interrupt event bit positions
  localparam int EV_DONE    = 0;
  localparam int EV_ABORT   = 1;
  localparam int EV_IGNORED = 2;
  localparam int EV_NOP     = 3;
  localparam int EV_BITS    = 4;

endpackage

// ==== dmc_cal_if.sv ====
// Handshake between command decode and the calibration servo
`timescale 1ns/1ps
interface dmc_cal_if;
  logic        start;
  logic        long_mode;
  logic [13:0] target;
  logic        busy;
  logic        done;
  logic [13:0] value;

  modport ctl (output start, output long_mode, output target,
               input busy, input done, input value);
  modport cal (input start, input long_mode, input target,
               output busy, output done, output value);
endinterface

// ==== dmc_cal.sv ====
// Calibration servo and busy timer for one channel update
`timescale 1ns/1ps
module dmc_cal #(
  parameter int LOAD_CYC = dmc_pkg::LOAD_CYC,
  parameter int STEP_CYC = dmc_pkg::STEP_CYC
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Link to command decode
  dmc_cal_if.cal    cif
);

  localparam int TW = $clog2(LOAD_CYC + 1);

  // Servo needs its binary search finished inside the shortest busy window
  if (LOAD_CYC < dmc_pkg::SAR_CYC || STEP_CYC < dmc_pkg::SAR_CYC ||
      STEP_CYC > LOAD_CYC)
  begin : g_bad_timing
    $error("dmc_cal: busy counts too short or out of order");
  end

  typedef struct packed {
    logic          run;
    logic          sar_on;
    logic [TW-1:0] tmr;
    logic [13:0]   sar;
    logic [13:0]   tgt;
    logic [3:0]    idx;
    logic          done;
    logic [13:0]   value;
  } dmc_cal_st_t;

  dmc_cal_st_t r;
  dmc_cal_st_t n;

  ////////////////////////////////////////////////////////////////////////////
  // Successive approximation toward the target during the busy window
  always_comb
  begin
    n      = r;
    n.done = 1'b0;
    if (cif.start && !r.run)
    begin
      n.run    = 1'b1;
      n.sar_on = 1'b1;
      n.tgt    = cif.target;
      n.sar    = 14'h2000;
      n.idx    = 4'hD;
      n.tmr    = cif.long_mode ? TW'(LOAD_CYC - 1) : TW'(STEP_CYC - 1);
    end
    else if (r.run)
    begin
      if (r.sar_on)
      begin
        // Drop the trial bit if it overshoots the wanted level
        if (r.sar > r.tgt)
          n.sar[r.idx] = 1'b0;
        if (r.idx == 4'h0)
          n.sar_on = 1'b0;
        else
        begin
          n.idx = r.idx - 4'h1;
          n.sar[r.idx - 4'h1] = 1'b1;
        end
      end
      if (r.tmr != '0)
        n.tmr = r.tmr - TW'(1);
      else if (!r.sar_on)
      begin
        n.run   = 1'b0;
        n.done  = 1'b1;
        n.value = r.sar;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign cif.busy  = r.run;
  assign cif.done  = r.done;
  assign cif.value = r.value;

endmodule // dmc_cal

// ==== dmc_ctrl.sv ====
// Serial command decode, channel levels and APB registers of the DAC
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module dmc_ctrl #(
  parameter int LOAD_CYC = dmc_pkg::LOAD_CYC,
  parameter int STEP_CYC = dmc_pkg::STEP_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link pins
  input  wire logic        sclk,
  input  wire logic        sync_n,
  input  wire logic        din,
  output logic             dout,
  output logic             busy_n,
  // Static control pins
  input  wire logic        chain_enable,
  input  wire logic        power_down_in,
  input  wire logic        reset_pin_n,
  // Channel update port
  output logic             upd_valid,
  output logic      [3:0]  upd_channel,
  output logic      [13:0] upd_level,
  output logic      [13:0] upd_signed,
  output logic             dac_powered_down,
  // Interrupt
  output logic             irq
);

  localparam int NCH = dmc_pkg::CHANNELS;
  localparam int LB  = dmc_pkg::LEVEL_BITS;
  localparam int EB  = dmc_pkg::EV_BITS;

  typedef struct packed {
    // Two-flop synchronisers; sclk and sync add one history stage
    logic [1:0]            sclk_s;
    logic                  sclk_d;
    logic [1:0]            sync_s;
    logic                  sync_d;
    logic [1:0]            din_s;
    logic [1:0]            chain_s;
    logic [1:0]            pd_s;
    logic [1:0]            rst_s;
    // Frame engine
    logic                  active;
    logic [4:0]            cnt;
    logic [17:0]           sr;
    logic                  dout;
    // Update tracking
    logic                  cal_start;
    logic                  cal_long;
    logic [13:0]           cal_tgt;
    logic [3:0]            cur_ch;
    logic [1:0]            last_mode;
    logic [NCH-1:0][LB-1:0] lvl;
    logic                  upd_valid;
    logic [13:0]           upd_level;
    // Registers
    logic [0:0]            ctrl;
    logic [EB-1:0]         irq_st;
    logic [EB-1:0]         irq_en;
    logic                  ack;
    logic [31:0]           prdata;
    logic                  slverr;
  } dmc_st_t;

  dmc_st_t   r;
  dmc_st_t   n;
  dmc_cal_if cif ();

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Offset binary to two's complement: flip the top bit
  function automatic logic [13:0] to_signed(input logic [13:0] lvl);
    to_signed = {~lvl[13], lvl[12:0]};
  endfunction

  // Quarter-step move with clamping at both ends of the range
  function automatic logic [13:0] step_level(input logic [13:0] lvl,
                                             input logic [6:0]  stp,
                                             input logic        up);
    logic [14:0] sum;
    sum = 15'h0;
    if (up)
    begin
      sum = {1'b0, lvl} + {8'h00, stp};
      step_level = sum[14] ? dmc_pkg::LEVEL_MAX : sum[13:0];
    end
    else
      step_level = (lvl < {7'h00, stp}) ? 14'h0000 : lvl - {7'h00, stp};
  endfunction

  // Register address decode, true when the offset is mapped
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == dmc_pkg::ADDR_CTRL) || (a == dmc_pkg::ADDR_STATUS) ||
             (a == dmc_pkg::ADDR_IRQ_ST) || (a == dmc_pkg::ADDR_IRQ_CLR) ||
             (a == dmc_pkg::ADDR_IRQ_EN) ||
             (a >= dmc_pkg::ADDR_CH_BASE && a <= dmc_pkg::ADDR_CH_END &&
              a[1:0] == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic          sclk_fall;
    logic          sclk_rise;
    logic          frame_fall;
    logic          frame_rise;
    logic          busy;
    logic          exec;
    logic [17:0]   word;
    logic [17:0]   shifted;
    logic [3:0]    ch;
    logic [EB-1:0] ev;
    logic [EB-1:0] clr;
    logic          acc;
    logic          wr_go;
    logic [3:0]    rd_ch;

    n           = r;
    ev          = '0;
    clr         = '0;
    exec        = 1'b0;
    word        = r.sr;
    ch          = 4'h0;
    n.cal_start = 1'b0;
    n.upd_valid = 1'b0;

    // Pins cross into pclk; only the second stage is looked at
    n.sclk_s  = {r.sclk_s[0], sclk};
    n.sync_s  = {r.sync_s[0], sync_n};
    n.din_s   = {r.din_s[0], din};
    n.chain_s = {r.chain_s[0], chain_enable};
    n.pd_s    = {r.pd_s[0], power_down_in};
    n.rst_s   = {r.rst_s[0], reset_pin_n};
    n.sclk_d  = r.sclk_s[1];
    n.sync_d  = r.sync_s[1];

    sclk_fall  = r.sclk_d & ~r.sclk_s[1];
    sclk_rise  = ~r.sclk_d & r.sclk_s[1];
    frame_fall = r.sync_d & ~r.sync_s[1];
    frame_rise = ~r.sync_d & r.sync_s[1];
    busy       = cif.busy | r.cal_start;
    shifted    = {r.sr[16:0], r.din_s[1]};

    // Frame start clears the bit counter
    if (frame_fall)
    begin
      n.active = r.ctrl[dmc_pkg::CTRL_LINK_EN];
      n.cnt    = 5'h00;
    end
    // Falling serial edges shift while framed and idle
    else if (sclk_fall && !r.sync_s[1] && r.active)
    begin
      if (busy)
        ev[dmc_pkg::EV_IGNORED] = 1'b1;
      else if (r.chain_s[1])
      begin
        n.sr = shifted;
        if (r.cnt != dmc_pkg::FULL_CNT)
          n.cnt = r.cnt + 5'h01;
      end
      else if (r.cnt != dmc_pkg::FULL_CNT)
      begin
        n.sr  = shifted;
        n.cnt = r.cnt + 5'h01;
        // Eighteenth edge hands the word over at once
        if (r.cnt == dmc_pkg::LAST_BIT)
        begin
          exec     = 1'b1;
          word     = shifted;
          n.active = 1'b0;
        end
      end
    end
    // Frame end: chain mode acts here, standalone drops short words
    else if (frame_rise && r.active)
    begin
      n.active = 1'b0;
      if (r.cnt == dmc_pkg::FULL_CNT && r.chain_s[1])
        exec = !busy;
      else if (r.cnt != dmc_pkg::FULL_CNT)
        ev[dmc_pkg::EV_ABORT] = 1'b1;
    end

    // Chain output changes on rising serial edges
    if (sclk_rise && r.chain_s[1] && !busy)
      n.dout = r.sr[dmc_pkg::WORD_BITS-1];

    // Command execution; field split is mode, address, data
    if (exec)
    begin
      ch          = word[dmc_pkg::CHAN_HI:dmc_pkg::CHAN_LO];
      n.last_mode = word[dmc_pkg::MODE_HI:dmc_pkg::MODE_LO];
      case (word[dmc_pkg::MODE_HI:dmc_pkg::MODE_LO])
        dmc_pkg::MODE_LOAD:
        begin
          n.lvl[ch]   = {word[dmc_pkg::CODE_HI:0], 2'b00};
          n.cal_long  = 1'b1;
          n.cal_start = 1'b1;
        end
        dmc_pkg::MODE_INC, dmc_pkg::MODE_DEC:
        begin
          // Seven bits cap the step at 127 quarters
          n.lvl[ch]   = step_level(r.lvl[ch],
                                   word[dmc_pkg::STEP_HI:0],
                                   word[dmc_pkg::MODE_LO]);
          n.cal_long  = 1'b0;
          n.cal_start = 1'b1;
        end
        dmc_pkg::MODE_NOP:
          ev[dmc_pkg::EV_NOP] = 1'b1;
        default:
          ev[dmc_pkg::EV_NOP] = 1'b1;
      endcase
      n.cur_ch  = ch;
      n.cal_tgt = n.lvl[ch];
    end

    // Servo finished: report the settled level
    if (cif.done)
    begin
      n.upd_valid           = 1'b1;
      n.upd_level           = cif.value;
      ev[dmc_pkg::EV_DONE]  = 1'b1;
    end

    // Reset pin returns every channel to its power-on code
    if (!r.rst_s[1])
    begin
      for (int i = 0; i < NCH; i++)
        n.lvl[i] = {dmc_pkg::CODE_RESET, 2'b00};
      n.active = 1'b0;
    end

    // APB: one wait state, write lands on the ready edge
    acc      = psel && penable;
    n.ack    = acc && !r.ack;
    wr_go    = acc && r.ack && pwrite && !r.slverr;
    rd_ch    = paddr[5:2];
    if (acc && !r.ack)
    begin
      n.slverr = !mapped(paddr);
      n.prdata = 32'h0000_0000;
      if (!pwrite)
        case (paddr)
          dmc_pkg::ADDR_CTRL:   n.prdata = {31'h0, r.ctrl};
          dmc_pkg::ADDR_STATUS: n.prdata = {24'h0, r.last_mode, r.cur_ch,
                                            r.pd_s[1], busy};
          dmc_pkg::ADDR_IRQ_ST: n.prdata = {28'h0, r.irq_st};
          dmc_pkg::ADDR_IRQ_EN: n.prdata = {28'h0, r.irq_en};
          default:
            // Only mapped channel slots read back; holes and IRQ_CLR give 0
            if (paddr >= dmc_pkg::ADDR_CH_BASE && mapped(paddr))
              n.prdata = {18'h0, r.lvl[rd_ch]};
        endcase
    end
    if (wr_go)
      case (paddr)
        dmc_pkg::ADDR_CTRL:    n.ctrl   = pwdata[0:0];
        dmc_pkg::ADDR_IRQ_CLR: clr      = pwdata[EB-1:0];
        dmc_pkg::ADDR_IRQ_EN:  n.irq_en = pwdata[EB-1:0];
        default:               n.ctrl   = r.ctrl;
      endcase

    // Sticky events: a set in the clearing cycle survives
    n.irq_st = (r.irq_st & ~clr) | ev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; pin synchronisers start at their idle levels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r          <= '0;
      r.sclk_s   <= 2'b11;
      r.sclk_d   <= 1'b1;
      r.sync_s   <= 2'b11;
      r.sync_d   <= 1'b1;
      r.chain_s  <= 2'b00;
      r.pd_s     <= 2'b00;
      r.rst_s    <= 2'b11;
      r.ctrl     <= dmc_pkg::CTRL_RESET;
      for (int i = 0; i < NCH; i++)
        r.lvl[i] <= {dmc_pkg::CODE_RESET, 2'b00};
    end
    else
      r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration servo and busy timer
  assign cif.start     = r.cal_start;
  assign cif.long_mode = r.cal_long;
  assign cif.target    = r.cal_tgt;

  dmc_cal #(
    .LOAD_CYC (LOAD_CYC),
    .STEP_CYC (STEP_CYC)
  ) u_cal (
    .pclk    (pclk),
    .presetn (presetn),
    .cif     (cif.cal)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign busy_n           = !(cif.busy | r.cal_start);
  assign dout             = r.dout;
  assign upd_valid        = r.upd_valid;
  assign upd_channel      = r.cur_ch;
  assign upd_level        = r.upd_level;
  assign upd_signed       = to_signed(r.upd_level);
  assign dac_powered_down = r.pd_s[1];
  assign prdata           = r.prdata;
  assign pready           = r.ack;
  assign pslverr          = r.ack & r.slverr;
  assign irq              = |(r.irq_st & r.irq_en);

endmodule // dmc_ctrl

// ==== dmc_props.sv ====
// Port-level checker for the DAC mode control block
`timescale 1ns/1ps
module dmc_props #(
  parameter int LOAD_CYC = 5000,
  parameter int STEP_CYC = 200
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Watched ports
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        busy_n,
  input wire logic        upd_valid,
  input wire logic [13:0] upd_level,
  input wire logic [13:0] upd_signed,
  input wire logic        power_down_in,
  input wire logic        dac_powered_down,
  input wire logic        irq
);
  int low_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
//////////////////////////////////////////////////////////////////////////////
  // Busy period length; a counter, since the period is too long to unroll
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      low_r <= 0;
    else
      low_r <= busy_n ? 0 : low_r + 1;

  // Release of busy and the update pulse
  // The update pulse is registered, so it trails the release by one cycle
  AST_RISE_DONE: assert property ($rose(busy_n) |=> upd_valid)
    else $error("busy released without update pulse");
  AST_DONE_RISE: assert property (
    upd_valid |-> busy_n && $past(busy_n) && !$past(busy_n, 2))
    else $error("update pulse outside busy release");
  AST_BUSY_MIN: assert property ($fell(busy_n) |-> !busy_n [*8])
    else $error("servo period too short");
  AST_BUSY_LEN: assert property (
    $rose(busy_n) |-> low_r inside
      {[STEP_CYC:STEP_CYC + 2], [LOAD_CYC:LOAD_CYC + 2]})
    else $error("busy period length off");
  AST_BUSY_MAX: assert property (
    !busy_n |-> low_r <= LOAD_CYC + 2)
    else $error("busy held too long");
  AST_IDLE_GAP: assert property ($rose(busy_n) |-> busy_n [*8])
    else $error("new update straight after release");
  AST_SIGNED: assert property (
    upd_signed == {~upd_level[13], upd_level[12:0]})
    else $error("signed level not offset binary flip");
  // Register bus and static pins
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_PD_FOLLOW: assert property (power_down_in [*5] |-> dac_powered_down)
    else $error("power-down not mirrored");
  COV_UPD: cover property (upd_valid);
  COV_ERR: cover property (pslverr);
  COV_IRQ: cover property (irq);
endmodule // dmc_props

bind dmc_ctrl dmc_props #(.LOAD_CYC(LOAD_CYC), .STEP_CYC(STEP_CYC)) u_props (
  .pclk, .presetn, .pready, .pslverr, .busy_n, .upd_valid, .upd_level,
  .upd_signed, .power_down_in, .dac_powered_down, .irq);

// ==== dmc_host.sv ====
// Serial host model: frame, link clock and data pins
`timescale 1ns/1ps
module dmc_host (
  // Serial pins toward the device
  output logic sclk,
  output logic sync_n,
  output logic din
);
//////////////////////////////////////////////////////////////////////////////
  // Idle: frame high, clock parked high
  initial
  begin
    sclk = 1'h1;
    sync_n = 1'h1;
    din = 1'h0;
  end

  // Shift n bits MSB first at 125 ns; tail delays the frame end
  task automatic frame(input logic [17:0] w, input int n, input int tail);
    int i;
    #250;
    sync_n = 1'h0;
    #20;
    for (i = 0; i < n; i++)
    begin
      din = w[17 - i];
      #31;
      sclk = 1'h0;
      #62.5;
      sclk = 1'h1;
      #31.5;
    end
    #(20 + tail);
    sync_n = 1'h1;
    din = ~din; // Released line shows no stale value
  endtask
endmodule // dmc_host

// ==== test_multichannel_dac_mode_control.sv ====
// Self-checking bench for the DAC mode control block
`timescale 1ns/1ps
module test_multichannel_dac_mode_control;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        sclk, sync_n, din, dout, busy_n, irq, upd_valid, pdn;
  logic        chain_enable, power_down_in, reset_pin_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  upd_channel;
  logic [13:0] upd_level, upd_signed;
  logic [17:0] ew;
  int          errors, checks, nupd, seed, i, c, lv[16];

  dmc_ctrl #(.LOAD_CYC(600), .STEP_CYC(20)) dut_u (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sclk,
    .sync_n, .din, .dout, .busy_n, .chain_enable, .power_down_in,
    .reset_pin_n, .upd_valid, .upd_channel, .upd_level, .upd_signed,
    .dac_powered_down(pdn), .irq);
  dmc_host host_u (.sclk, .sync_n, .din);

  always #2.5 pclk = ~pclk;
//////////////////////////////////////////////////////////////////////////////
  // Every update pulse is compared with the model
  always @(posedge pclk)
    if (upd_valid === 1'h1)
    begin
      nupd++;
      chk(upd_channel, ew[15:12]);
      chk(upd_level, lv[ew[15:12]]);
      chk(upd_signed, lv[ew[15:12]] ^ 32'h2000);
    end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One APB transfer; waits for ready under a bound
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 8 && pready !== 1'h1; n++)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    errors += (n == 8);
    if (n == 8)
      print_verdict();
  endtask

  // Model: saturating quarter steps on a 14-bit level
  task automatic model(input logic [17:0] v);
    int k;
    ew = v;
    k = v[15:12];
    case (v[17:16])
      dmc_pkg::MODE_LOAD: lv[k] = v[11:0] * 4;
      dmc_pkg::MODE_INC: lv[k] = lv[k] + v[6:0] > 16383 ? 16383
                                 : lv[k] + v[6:0];
      dmc_pkg::MODE_DEC: lv[k] = lv[k] < v[6:0] ? 0 : lv[k] - v[6:0];
      default: ;
    endcase
  endtask

  // Send a frame, wait out busy, compare count and level
  task automatic frm(input logic [17:0] v, input int n, input bit m,
                     input int ups);
    int k;
    if (m)
      model(v);
    host_u.frame(v, n, chain_enable ? 400 : 0);
    repeat (8) @(posedge pclk);
    for (k = 0; k < 900 && busy_n !== 1'h1; k++)
      @(posedge pclk);
    errors += (k == 900);
    if (k == 900)
      print_verdict();
    // Update pulse trails the busy release; let the counter see it first
    repeat (2) @(posedge pclk);
    chk(nupd, ups);
    apb(1'h0, dmc_pkg::ADDR_CH_BASE + 12'(4 * v[15:12]), 32'h0);
    chk(rd, lv[v[15:12]]);
  endtask

  task automatic rdall;
    for (i = 0; i < 16; i++)
    begin
      apb(1'h0, dmc_pkg::ADDR_CH_BASE + 12'(4 * i), 32'h0);
      chk(rd, lv[i]);
    end
  endtask

  // Main sequence
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, chain_enable} = '0;
    {power_down_in, paddr, pwdata, reset_pin_n} = 46'h1;
    seed = 32'hE9D0FD93;
    foreach (lv[k])
      lv[k] = 32'h2000;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    rdall();
    apb(1'h0, dmc_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'h0, 12'h020, 32'h0);
    chk(er, 32'h1);
    chk(rd, 32'h0);
    apb(1'h1, dmc_pkg::ADDR_IRQ_EN, 32'hF);
    apb(1'h0, dmc_pkg::ADDR_IRQ_EN, 32'h0);
    chk(rd, 32'hF);
    // Loads at both code ends, then saturating and random steps
    for (c = 0; c < 6; c++)
    begin
      i = $random(seed);
      frm({2'h0, 4'(i), c == 0 ? 12'h0 : c == 1 ? 12'hFFF : 12'(i >> 8)},
          18, 1'h1, nupd + 1);
      frm({c % 2 ? dmc_pkg::MODE_INC : dmc_pkg::MODE_DEC, 4'(i), 5'h0,
           c < 2 ? 7'h7F : c == 2 ? 7'h1 : 7'(i >> 20)},
          18, 1'h1, nupd + 1);
    end
    frm({2'h3, 4'(i), 12'(i)}, 18, 1'h1, nupd);
    frm({2'h0, 4'(i), 12'h123}, 10, 1'h0, nupd);
    // Second frame lands inside the first one's busy period
    model({2'h0, 4'(i), 12'h5A5});
    host_u.frame({2'h0, 4'(i), 12'h5A5}, 18, 0);
    frm({2'h0, 4'(i + 1), 12'h0F0}, 18, 1'h0, nupd + 1);
    apb(1'h0, dmc_pkg::ADDR_IRQ_ST, 32'h0);
    chk(rd, 32'hF);
    chk(irq, 32'h1);
    apb(1'h1, dmc_pkg::ADDR_IRQ_CLR, 32'hF);
    apb(1'h1, dmc_pkg::ADDR_IRQ_EN, 32'h0);
    // Chain pin set an edge early so the frame sees it settled
    chain_enable <= 1'h1;
    @(posedge pclk);
    chk(irq, 32'h0);
    // Masked events in chain mode, then unmasked
    frm({2'h0, 4'(i + 2), 12'hC3C}, 18, 1'h1, nupd + 1);
    // After a full chain word the output shows its top mode bit
    frm({2'h3, 4'(i + 2), 12'(i)}, 18, 1'h1, nupd);
    chk(dout, 32'h1);
    chain_enable <= 1'h0;
    chk(irq, 32'h0);
    apb(1'h1, dmc_pkg::ADDR_IRQ_EN, 32'hF);
    @(posedge pclk);
    chk(irq, 32'h1);
    // Link disabled: a whole frame is ignored
    apb(1'h1, dmc_pkg::ADDR_CTRL, 32'h0);
    frm({2'h0, 4'(i + 3), 12'h321}, 18, 1'h0, nupd);
    apb(1'h1, dmc_pkg::ADDR_CTRL, 32'h1);
    power_down_in <= 1'h1;
    repeat (6) @(posedge pclk);
    chk(pdn, 32'h1);
    apb(1'h0, dmc_pkg::ADDR_STATUS, 32'h0);
    chk(rd[1], 32'h1);
    power_down_in <= 1'h0;
    // Reset pin returns all channels to the power-on level
    reset_pin_n <= 1'h0;
    repeat (6) @(posedge pclk);
    reset_pin_n <= 1'h1;
    foreach (lv[k])
      lv[k] = 32'h2000;
    rdall();
    print_verdict();
  end
endmodule // test_multichannel_dac_mode_control
